// File: shared/dsf_pkg.sv
/*
  Shared constants and types for the diagnostic flag register bank.
  Assumes a 100 MHz system clock and 16-bit serial frames from the host.
*/
package dsf_pkg;
  // System clock rate and supply settle time
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SETTLE_MS = 250;
  localparam int unsigned SETTLE_CYC = CLK_HZ / 1000 * SETTLE_MS;
  // Serial frame layout
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned RW_BIT = 15;
  localparam int unsigned ADDR_MSB = 14;
  localparam int unsigned ADDR_LSB = 8;
  // Register byte addresses
  localparam logic [6:0] ADDR_DIAG = 7'h02;
  localparam logic [6:0] ADDR_GX_LOW = 7'h04;
  localparam logic [6:0] ADDR_GX_HIGH = 7'h06;
  localparam logic [6:0] ADDR_GY_LOW = 7'h08;
  localparam logic [6:0] ADDR_GY_HIGH = 7'h0a;
  localparam logic [6:0] ADDR_GZ_LOW = 7'h0c;
  localparam logic [6:0] ADDR_GZ_HIGH = 7'h0e;
  localparam logic [6:0] ADDR_BIAS = 7'h66;
  localparam logic [6:0] ADDR_CMD = 7'h68;
  localparam logic [6:0] ADDR_FW_REV = 7'h6c;
  localparam logic [6:0] ADDR_FW_DM = 7'h6e;
  localparam logic [6:0] ADDR_FW_YEAR = 7'h70;
  localparam logic [6:0] ADDR_DEV_NUM = 7'h72;
  localparam logic [6:0] ADDR_SERIAL = 7'h74;
  localparam logic [6:0] ADDR_SCR [3] = '{7'h76, 7'h78, 7'h7a};
  localparam logic [6:0] ADDR_FW_LOW = 7'h7c;
  localparam logic [6:0] ADDR_FW_HIGH = 7'h7e;
  // Reset values
  localparam logic [15:0] DIAG_RST = 16'h0000;
  localparam logic [15:0] BIAS_RST = 16'h070a;
  localparam logic [15:0] SCR_RST = 16'h0000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  // Flag bit positions
  localparam int unsigned FLAG_OVERRUN = 1;
  localparam int unsigned FLAG_UPDATE = 2;
  localparam int unsigned FLAG_SERIAL = 3;
  localparam int unsigned FLAG_STANDBY = 4;
  localparam int unsigned FLAG_SENSOR = 5;
  localparam int unsigned FLAG_MEMORY = 6;
  localparam int unsigned FLAG_CLOCK = 7;
  // Command bit positions
  localparam int unsigned CMD_SELF_TEST = 2;
  localparam int unsigned CMD_FLASH_UPDATE = 3;
  localparam int unsigned CMD_FLASH_TEST = 4;
  localparam int unsigned CMD_SOFT_RESET = 7;
  // Sync mode code for scaled sync
  localparam logic [2:0] SYNC_SCALED = 3'h2;

  // Gyro outputs, each a 32-bit twos complement value
  typedef struct packed {
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] z;
  } dsf_gyro_s;

  // Monitor events and levels from the sensor core
  typedef struct packed {
    logic syncLockFail;
    logic flashTestDone;
    logic flashTestBad;
    logic selfTestDone;
    logic selfTestFail;
    logic flashUpdDone;
    logic flashUpdFail;
    logic overrun;
  } dsf_mon_s;

  // One-cycle command pulses to the sensor core
  typedef struct packed {
    logic softReset;
    logic flashTest;
    logic flashUpdate;
    logic selfTest;
  } dsf_cmd_s;

  // Supply monitor states
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_DOWN = 2'b01,
    PWR_SETTLE = 2'b10
  } dsf_power_e;
endpackage : dsf_pkg

// File: rtl/dsf_spi_link.sv
/*
  Serial slave for the register bank: 16-bit frames, clock idles high.
  Assumes csN, sclk and mosi are asynchronous pins sampled by clk_sys.
*/
`timescale 1ns/10ps
module dsf_spi_link (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic csN,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic [15:0] txWord,
  output logic miso,
  output logic misoOeN,
  output logic rxValid,
  output logic [15:0] rxWord,
  output logic frameErr
);
  // Two-stage synchronisers, then one stage for edge finding
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic csPrev;
  logic sclkPrev;
  logic [3:0] bitCnt; // Edges seen modulo the frame length
  logic [15:0] rxShift;
  logic [15:0] txShift;
  logic sclkRise;
  logic sclkFall;
  logic csRise;
  logic csFall;
  localparam logic [15:0] WORD_ZERO = dsf_pkg::WORD_ZERO; // Idle word, declared before any use

  // Pin synchronisers; only syncB feeds logic
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      syncA <= 3'h7;
      syncB <= 3'h7;
      csPrev <= 1'b1;
      sclkPrev <= 1'b1;
    end else if (clkEn) begin
      syncA <= {csN, sclk, mosi};
      syncB <= syncA;
      csPrev <= syncB[2];
      sclkPrev <= syncB[1];
    end
  end

  assign sclkRise = !syncB[2] && syncB[1] && !sclkPrev;
  assign sclkFall = !syncB[2] && !syncB[1] && sclkPrev;
  assign csRise = syncB[2] && !csPrev;
  assign csFall = !syncB[2] && csPrev;

  // Receive side: sample on rising edges, word every 16 edges
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bitCnt <= 4'h0;
      rxShift <= WORD_ZERO;
      rxWord <= WORD_ZERO;
      rxValid <= 1'b0;
    end else if (clkEn) begin
      rxValid <= 1'b0;
      if (csFall) begin
        bitCnt <= 4'h0;
      end else if (sclkRise) begin
        bitCnt <= bitCnt + 4'h1;
        rxShift <= {rxShift[14:0], syncB[0]};
        if (bitCnt == 4'(dsf_pkg::FRAME_BITS - 1)) begin
          rxWord <= {rxShift[14:0], syncB[0]};
          rxValid <= 1'b1;
        end
      end
    end
  end

  // Count left over at deselect means a bad frame length
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frameErr <= 1'b0;
    end else if (clkEn) begin
      frameErr <= csRise && (bitCnt != 4'h0);
    end
  end

  // Transmit side: load on the frame's first falling edge, then shift
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txShift <= WORD_ZERO;
    end else if (clkEn && sclkFall) begin
      if (bitCnt == 4'h0) begin
        txShift <= txWord;
      end else begin
        txShift <= {txShift[14:0], 1'b0};
      end
    end
  end

  assign miso = txShift[15];
  assign misoOeN = syncB[2]; // Driven only while selected
endmodule : dsf_spi_link

// File: rtl/dsf_diag_regs.sv
/*
  Diagnostic error flags and the upper register map of the unit.
  Assumes monitor inputs come from logic on clk_sys; the supply
  comparator and the serial pins are asynchronous.
*/
`timescale 1ns/10ps
module dsf_diag_regs #(
  parameter int unsigned SETTLE_CYCLES = dsf_pkg::SETTLE_CYC,
  parameter logic [15:0] FW_REV = 16'h0101, // Arbitrary value
  parameter logic [15:0] FW_DAY_MONTH = 16'h0101, // Arbitrary value
  parameter logic [15:0] FW_YEAR = 16'h0001, // Arbitrary value
  parameter logic [15:0] DEV_NUMBER = 16'h1234, // Arbitrary value
  parameter logic [15:0] UNIT_SERIAL = 16'h0001 // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic spiCsN,
  input wire logic spiSclk,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOeN,
  input wire logic supplyLow,
  input wire logic [2:0] syncMode,
  input wire dsf_pkg::dsf_mon_s mon,
  input wire dsf_pkg::dsf_gyro_s gyro,
  output dsf_pkg::dsf_cmd_s cmd,
  output logic dataHalt,
  output logic reinit,
  output logic [15:0] biasNull
);
  logic rxValid; // Word received from the host
  logic [15:0] rxWord;
  logic frameErr; // Bad frame length pulse
  logic [15:0] txWord; // Answer for the next frame
  logic [15:0] flags; // Sticky diagnostic flags
  logic [15:0] setVec; // Per-bit set events this cycle
  logic [15:0] scratch [3];
  logic [31:0] flashWrites;
  logic [1:0] lowSync; // Supply comparator synchroniser
  dsf_pkg::dsf_power_e pwrState;
  dsf_pkg::dsf_power_e next_pwrState;
  logic [$clog2(SETTLE_CYCLES + 1)-1:0] settleCnt;
  logic isWrite;
  logic isRead;
  logic [6:0] rxAddr;
  logic clearFlags; // Diag register is being read
  logic [15:0] readData;

  // Same word address, ignoring the byte select bit
  function automatic logic hitWord(input logic [6:0] a, input logic [6:0] off);
    hitWord = (a[6:1] == off[6:1]);
  endfunction : hitWord

  // Byte write: odd address writes the high byte
  function automatic logic [15:0] mergeByte(input logic [15:0] old, input logic hi, input logic [7:0] b);
    mergeByte = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction : mergeByte

  // Serial slave
  dsf_spi_link uLink (
    .clk_sys(clk_sys),
    .rst(rst),
    .clkEn(clkEn),
    .csN(spiCsN),
    .sclk(spiSclk),
    .mosi(spiMosi),
    .txWord(txWord),
    .miso(spiMiso),
    .misoOeN(spiMisoOeN),
    .rxValid(rxValid),
    .rxWord(rxWord),
    .frameErr(frameErr)
  );

  // Frame decode
  assign rxAddr = rxWord[dsf_pkg::ADDR_MSB:dsf_pkg::ADDR_LSB];
  assign isWrite = rxValid && rxWord[dsf_pkg::RW_BIT];
  assign isRead = rxValid && !rxWord[dsf_pkg::RW_BIT];
  assign clearFlags = isRead && hitWord(rxAddr, dsf_pkg::ADDR_DIAG);

  // Supply comparator is asynchronous: two flops first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lowSync <= 2'b00;
    end else if (clkEn) begin
      lowSync <= {lowSync[0], supplyLow};
    end
  end

  // Supply state: halt while low, resume after a full settle time
  always_comb begin
    next_pwrState = pwrState;
    case (pwrState)
      dsf_pkg::PWR_RUN: begin
        if (lowSync[1]) next_pwrState = dsf_pkg::PWR_DOWN;
      end
      dsf_pkg::PWR_DOWN: begin
        if (!lowSync[1]) next_pwrState = dsf_pkg::PWR_SETTLE;
      end
      dsf_pkg::PWR_SETTLE: begin
        // A dip restarts the whole wait
        if (lowSync[1]) next_pwrState = dsf_pkg::PWR_DOWN;
        else if (settleCnt == ($bits(settleCnt))'(SETTLE_CYCLES - 1)) next_pwrState = dsf_pkg::PWR_RUN;
      end
      default: next_pwrState = dsf_pkg::PWR_DOWN;
    endcase
  end

  // State register and settle counter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwrState <= dsf_pkg::PWR_RUN;
      settleCnt <= '0;
      reinit <= 1'b0;
    end else if (clkEn) begin
      pwrState <= next_pwrState;
      settleCnt <= (pwrState == dsf_pkg::PWR_SETTLE) ? settleCnt + 1'b1 : '0;
      reinit <= (pwrState == dsf_pkg::PWR_SETTLE) && (next_pwrState == dsf_pkg::PWR_RUN);
    end
  end

  // Processing halts in both low and settling states
  assign dataHalt = (pwrState != dsf_pkg::PWR_RUN);

  // Flag set events, one per monitored condition
  always_comb begin
    setVec = 16'h0000;
    setVec[dsf_pkg::FLAG_CLOCK] = mon.syncLockFail && (syncMode == dsf_pkg::SYNC_SCALED);
    setVec[dsf_pkg::FLAG_MEMORY] = mon.flashTestDone && mon.flashTestBad;
    setVec[dsf_pkg::FLAG_SENSOR] = mon.selfTestDone && mon.selfTestFail;
    setVec[dsf_pkg::FLAG_STANDBY] = (pwrState == dsf_pkg::PWR_DOWN);
    setVec[dsf_pkg::FLAG_SERIAL] = frameErr;
    setVec[dsf_pkg::FLAG_UPDATE] = mon.flashUpdDone && mon.flashUpdFail;
    setVec[dsf_pkg::FLAG_OVERRUN] = mon.overrun;
  end

  // Sticky flags: a set in the clearing cycle survives the clear
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : gFlag
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          flags[gi] <= dsf_pkg::DIAG_RST[gi];
        end else if (clkEn) begin
          if (setVec[gi]) flags[gi] <= 1'b1;
          else if (clearFlags) flags[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Writable words; commands are write only and writes to their upper byte are ignored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      biasNull <= dsf_pkg::BIAS_RST;
      cmd <= '0;
    end else if (clkEn) begin
      cmd <= '0;
      if (isWrite && hitWord(rxAddr, dsf_pkg::ADDR_BIAS)) begin
        biasNull <= mergeByte(biasNull, rxAddr[0], rxWord[7:0]);
      end
      if (isWrite && rxAddr == dsf_pkg::ADDR_CMD) begin
        cmd.selfTest <= rxWord[dsf_pkg::CMD_SELF_TEST];
        cmd.flashUpdate <= rxWord[dsf_pkg::CMD_FLASH_UPDATE];
        cmd.flashTest <= rxWord[dsf_pkg::CMD_FLASH_TEST];
        cmd.softReset <= rxWord[dsf_pkg::CMD_SOFT_RESET];
      end
    end
  end

  // Scratch words; the flash copy is restored by the core, not here
  generate
    for (gi = 0; gi < 3; gi++) begin : gScr
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          scratch[gi] <= dsf_pkg::SCR_RST;
        end else if (clkEn && isWrite && hitWord(rxAddr, dsf_pkg::ADDR_SCR[gi])) begin
          scratch[gi] <= mergeByte(scratch[gi], rxAddr[0], rxWord[7:0]);
        end
      end
    end
  endgenerate

  // Flash write cycle counter, one count per completed update
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flashWrites <= 32'h0000_0000;
    end else if (clkEn && mon.flashUpdDone) begin
      flashWrites <= flashWrites + 32'h0000_0001;
    end
  end

  // Read multiplexer; unmapped words read as zero
  always_comb begin
    case ({rxAddr[6:1], 1'b0})
      dsf_pkg::ADDR_DIAG: readData = flags;
      dsf_pkg::ADDR_GX_LOW: readData = gyro.x[15:0];
      dsf_pkg::ADDR_GX_HIGH: readData = gyro.x[31:16];
      dsf_pkg::ADDR_GY_LOW: readData = gyro.y[15:0];
      dsf_pkg::ADDR_GY_HIGH: readData = gyro.y[31:16];
      dsf_pkg::ADDR_GZ_LOW: readData = gyro.z[15:0];
      dsf_pkg::ADDR_GZ_HIGH: readData = gyro.z[31:16];
      dsf_pkg::ADDR_BIAS: readData = biasNull;
      dsf_pkg::ADDR_FW_REV: readData = FW_REV;
      dsf_pkg::ADDR_FW_DM: readData = FW_DAY_MONTH;
      dsf_pkg::ADDR_FW_YEAR: readData = FW_YEAR;
      dsf_pkg::ADDR_DEV_NUM: readData = DEV_NUMBER;
      dsf_pkg::ADDR_SERIAL: readData = UNIT_SERIAL;
      dsf_pkg::ADDR_SCR[0]: readData = scratch[0];
      dsf_pkg::ADDR_SCR[1]: readData = scratch[1];
      dsf_pkg::ADDR_SCR[2]: readData = scratch[2];
      dsf_pkg::ADDR_FW_LOW: readData = flashWrites[15:0];
      dsf_pkg::ADDR_FW_HIGH: readData = flashWrites[31:16];
      default: readData = dsf_pkg::WORD_ZERO;
    endcase
  end

  // Answer is captured at the request and shifted out next frame
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txWord <= dsf_pkg::WORD_ZERO;
    end else if (clkEn && isRead) begin
      txWord <= readData;
    end
  end

  // Checks: bench keeps clkEn high while these are meant to hold
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence sDiagRead;
    clearFlags && clkEn;
  endsequence

  sequence sNoSet;
    setVec == 16'h0000;
  endsequence

  // A command bit gives one pulse, then the line drops again
  sequence sTestPulse;
    cmd.flashTest ##1 !cmd.flashTest;
  endsequence

  a_read_clears: assert property (sDiagRead and sNoSet |=> flags == 16'h0000)
    else $error("diag flags not cleared by read");
  a_read_returns: assert property (sDiagRead |=> txWord == $past(flags))
    else $error("diag read did not return old flags");
  a_set_wins: assert property (sDiagRead and setVec[dsf_pkg::FLAG_OVERRUN] |=> flags[dsf_pkg::FLAG_OVERRUN])
    else $error("set lost against clear");
  a_flag_sticky: assert property (flags[dsf_pkg::FLAG_SENSOR] && !clearFlags |=> flags[dsf_pkg::FLAG_SENSOR])
    else $error("flag dropped without read");
  a_clock_gate: assert property ($rose(flags[dsf_pkg::FLAG_CLOCK]) |-> $past(syncMode) == dsf_pkg::SYNC_SCALED)
    else $error("clock flag outside scaled sync");
  a_clock_set: assert property (mon.syncLockFail && syncMode == dsf_pkg::SYNC_SCALED && clkEn
                                |=> flags[dsf_pkg::FLAG_CLOCK])
    else $error("clock flag not set in scaled sync");
  a_memory_err: assert property (mon.flashTestDone && mon.flashTestBad && clkEn
                                 |=> flags[dsf_pkg::FLAG_MEMORY])
    else $error("memory flag not set");
  a_sensor_err: assert property (mon.selfTestDone && mon.selfTestFail && clkEn
                                 |=> flags[dsf_pkg::FLAG_SENSOR])
    else $error("sensor flag not set");
  a_standby_flag: assert property (pwrState == dsf_pkg::PWR_DOWN && clkEn
                                   |-> dataHalt ##1 flags[dsf_pkg::FLAG_STANDBY])
    else $error("standby flag or halt missing");
  // A frozen cycle holds the pulse, so only its first cycle is judged
  a_resume_done: assert property (reinit && $past(clkEn) |-> $past(pwrState) == dsf_pkg::PWR_SETTLE
                                  && pwrState == dsf_pkg::PWR_RUN)
    else $error("resume without settle");
  a_frame_err: assert property (frameErr && clkEn |=> flags[dsf_pkg::FLAG_SERIAL])
    else $error("serial flag not set");
  a_update_err: assert property (mon.flashUpdDone && mon.flashUpdFail && clkEn
                                 |=> flags[dsf_pkg::FLAG_UPDATE])
    else $error("update flag not set");
  a_overrun_flag: assert property (mon.overrun && clkEn |=> flags[dsf_pkg::FLAG_OVERRUN])
    else $error("overrun flag not set");
  a_gyro_high: assert property (isRead && clkEn && rxAddr == dsf_pkg::ADDR_GX_HIGH
                                |=> txWord == $past(gyro.x[31:16]))
    else $error("gyro high word wrong");
  // Reset itself is the antecedent, so this one must not be disabled by it
  a_bias_reset: assert property (@(posedge clk_sys) disable iff (1'b0)
                                 rst && clkEn |=> biasNull == dsf_pkg::BIAS_RST)
    else $error("bias word reset value wrong");
  a_count_step: assert property (mon.flashUpdDone && clkEn
                                 |=> flashWrites == $past(flashWrites) + 32'h0000_0001)
    else $error("flash write count did not step");
  a_cmd_pulse: assert property (isWrite && clkEn && rxAddr == dsf_pkg::ADDR_CMD
                                && rxWord[dsf_pkg::CMD_FLASH_TEST] |=> sTestPulse)
    else $error("flash test command pulse wrong");
endmodule : dsf_diag_regs

// File: tb/dsf_spi_host.sv
/*
  Host-side serial master that reads and writes the register bank.
  Assumes 16-bit frames, clock idling high, 125 ns clock period.
*/
`timescale 1ns/10ps
module dsf_spi_host (
  output logic csN,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  localparam realtime HALF = 62.5; // Half of the 125 ns serial clock
  // Idle lines: deselected, clock high
  initial begin
    csN = 1'b1;
    sclk = 1'b1;
    mosi = 1'b1;
  end
  // One frame, MSB first; nBits below 16 makes a short frame on purpose
  task automatic frame(input logic [15:0] tx, input int nBits, output logic [15:0] rx);
    rx = 16'h0000;
    csN = 1'b0;
    #(HALF);
    for (int i = 0; i < nBits; i++) begin
      sclk = 1'b0;
      mosi = tx[15-i]; // Data launched on the falling edge
      #(HALF);
      sclk = 1'b1;
      rx = {rx[14:0], miso}; // Sampled on the rising edge
      #(HALF);
    end
    #(HALF);
    csN = 1'b1;
    // Released line must not keep its last value
    mosi = ~mosi;
    #(4 * HALF);
  endtask : frame
endmodule : dsf_spi_host

// File: tb/tb.sv
/*
  Self-checking bench for the diagnostic flag register bank.
  Assumes the serial host model and a short supply settle count.
*/
`timescale 1ns/10ps
module tb;
  localparam int unsigned SETTLE = 50; // Shortened settle time
  localparam logic [15:0] DEVNUM = 16'h5a5a; // Arbitrary value
  logic clk_sys, rst, spiCsN, spiSclk, spiMosi, spiMiso, spiMisoOeN;
  logic supplyLow, dataHalt, reinit, clkEn;
  logic clrSeen; // Clears the pulse record at the next edge
  logic [2:0] syncMode;
  logic [15:0] biasNull, d;
  logic [3:0] seen = 4'h0; // Command pulses seen since last clear
  dsf_pkg::dsf_mon_s mon;
  dsf_pkg::dsf_gyro_s gyro;
  dsf_pkg::dsf_cmd_s cmd;
  int mismatches, testsRun;
  int pulses = 0;
  int reinits = 0;

  dsf_diag_regs #(.SETTLE_CYCLES(SETTLE), .DEV_NUMBER(DEVNUM)) DUT (.clk_sys(clk_sys), .rst(rst),
    .clkEn(clkEn), .spiCsN(spiCsN), .spiSclk(spiSclk), .spiMosi(spiMosi), .spiMiso(spiMiso),
    .spiMisoOeN(spiMisoOeN), .supplyLow(supplyLow), .syncMode(syncMode), .mon(mon), .gyro(gyro),
    .cmd(cmd), .dataHalt(dataHalt), .reinit(reinit), .biasNull(biasNull));
  dsf_spi_host host (.csN(spiCsN), .sclk(spiSclk), .mosi(spiMosi), .miso(spiMiso));

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Count one-cycle command and restart pulses
  always @(posedge clk_sys) begin
    if (clrSeen) begin
      seen <= 4'h0;
      pulses <= 0;
    end else begin
      seen <= seen | cmd;
      pulses <= pulses + ((cmd != 4'h0) ? 1 : 0);
    end
    reinits <= reinits + (reinit === 1'b1 ? 1 : 0);
  end

  task automatic give_verdict;
    if (mismatches == 0 && testsRun > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  // Read answer arrives in the following frame
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    logic [15:0] x;
    host.frame({1'b0, a, 8'h00}, 16, x);
    host.frame(16'h0000, 16, v);
  endtask : rd
  // Word write as low byte then high byte
  task automatic wr(input logic [6:0] a, input logic [15:0] w);
    logic [15:0] x;
    host.frame({1'b1, a, w[7:0]}, 16, x);
    host.frame({1'b1, a | 7'h01, w[15:8]}, 16, x);
  endtask : wr
  task automatic do_reset;
    rst = 1'b1;
    step(16);
    rst = 1'b0;
    step(4);
  endtask : do_reset

  task automatic t_reset;
    rd(dsf_pkg::ADDR_BIAS, d); chk(d, 16'h070a);
    chk(biasNull, 16'h070a);
    chk(16'(spiMisoOeN), 16'h0001); // Data line released while deselected
    rd(dsf_pkg::ADDR_DIAG, d); chk(d, 16'h0000);
    rd(dsf_pkg::ADDR_DEV_NUM, d); chk(d, DEVNUM);
    rd(7'h6a, d); chk(d, 16'h0000); // Reserved hole reads zero
    rd(dsf_pkg::ADDR_CMD, d); chk(d, 16'h0000);
  endtask : t_reset
  task automatic t_regs;
    for (int k = 0; k < 3; k++) wr(dsf_pkg::ADDR_SCR[k], 16'hc3a5 ^ 16'(k));
    for (int k = 0; k < 3; k++) begin
      rd(dsf_pkg::ADDR_SCR[k], d); chk(d, 16'hc3a5 ^ 16'(k));
    end
    wr(dsf_pkg::ADDR_BIAS, 16'h1e2d);
    rd(dsf_pkg::ADDR_BIAS, d); chk(d, 16'h1e2d);
    chk(biasNull, 16'h1e2d);
    wr(dsf_pkg::ADDR_FW_LOW, 16'hffff); // Read-only word ignores writes
    rd(dsf_pkg::ADDR_FW_LOW, d); chk(d, 16'h0000);
  endtask : t_regs
  task automatic t_flags;
    logic [7:0] ev [7] = '{8'h60, 8'h40, 8'h18, 8'h10, 8'h06, 8'h04, 8'h01};
    logic [15:0] ex [7] = '{16'h0040, 16'h0000, 16'h0020, 16'h0000, 16'h0004, 16'h0000, 16'h0002};
    // Events without a failure must leave the register clear
    for (int i = 0; i < 7; i++) begin
      mon = ev[i]; // Each event, the failed self test included, is applied once for one cycle
      step(1);
      mon = '0;
      step(2);
      rd(dsf_pkg::ADDR_DIAG, d); chk(d, ex[i]);
      rd(dsf_pkg::ADDR_DIAG, d); chk(d, 16'h0000);
    end
    rd(dsf_pkg::ADDR_FW_LOW, d); chk(d, 16'h0002);
    rd(dsf_pkg::ADDR_FW_HIGH, d); chk(d, 16'h0000);
    // Lock loss counts only in scaled sync
    mon.syncLockFail = 1'b1;
    rd(dsf_pkg::ADDR_DIAG, d); chk(d, 16'h0000);
    syncMode = dsf_pkg::SYNC_SCALED;
    rd(dsf_pkg::ADDR_DIAG, d); chk(d, 16'h0080);
    rd(dsf_pkg::ADDR_DIAG, d); chk(d, 16'h0080);
    mon.syncLockFail = 1'b0; // Sync frequency brought back in range
    rd(dsf_pkg::ADDR_DIAG, d); chk(d, 16'h0080);
    rd(dsf_pkg::ADDR_DIAG, d); chk(d, 16'h0000);
    // Persisting overrun, then the bench resets the unit through rst
    mon.overrun = 1'b1;
    rd(dsf_pkg::ADDR_DIAG, d); chk(d, 16'h0002);
    rd(dsf_pkg::ADDR_DIAG, d); chk(d, 16'h0002);
    mon.overrun = 1'b0;
    do_reset;
    rd(dsf_pkg::ADDR_DIAG, d); chk(d, 16'h0000);
    rd(dsf_pkg::ADDR_SCR[0], d); chk(d, 16'h0000);
  endtask : t_flags
  task automatic t_frame;
    // The pin enable is looked at mid-frame while the host clocks 15 bits
    fork
      host.frame(16'h0000, 15, d); // Short frame
      begin
        #500;
        chk(16'(spiMisoOeN), 16'h0000); // Device drives while selected
      end
    join
    step(10);
    host.frame(16'h0000, 16, d); // Host repeats the cut frame in full
    rd(dsf_pkg::ADDR_DIAG, d); chk(d, 16'h0008);
    rd(dsf_pkg::ADDR_DIAG, d); chk(d, 16'h0000);
  endtask : t_frame
  task automatic t_supply;
    int n;
    supplyLow = 1'b1;
    step(8);
    chk(16'(dataHalt), 16'h0001);
    rd(dsf_pkg::ADDR_DIAG, d); chk(d, 16'h0010);
    n = reinits;
    supplyLow = 1'b0;
    step(SETTLE - 5);
    chk(16'(dataHalt), 16'h0001);
    step(30);
    chk(16'(dataHalt), 16'h0000);
    chk(16'(reinits - n), 16'h0001);
    rd(dsf_pkg::ADDR_DIAG, d); chk(d, 16'h0010);
    rd(dsf_pkg::ADDR_DIAG, d); chk(d, 16'h0000);
  endtask : t_supply
  task automatic t_cmd;
    int bitPos [4] = '{dsf_pkg::CMD_SELF_TEST, dsf_pkg::CMD_FLASH_UPDATE, dsf_pkg::CMD_FLASH_TEST,
      dsf_pkg::CMD_SOFT_RESET};
    // Each command bit yields exactly one pulse on its own line
    for (int j = 0; j < 4; j++) begin
      clrSeen = 1'b1;
      step(1);
      clrSeen = 1'b0;
      host.frame({1'b1, dsf_pkg::ADDR_CMD, 8'(1 << bitPos[j])}, 16, d);
      step(10);
      chk({pulses[11:0], seen}, {12'h001, 4'(1 << j)});
    end
  endtask : t_cmd
  task automatic t_gyro;
    logic [6:0] lo [3] = '{dsf_pkg::ADDR_GX_LOW, dsf_pkg::ADDR_GY_LOW, dsf_pkg::ADDR_GZ_LOW};
    logic [6:0] hi [3] = '{dsf_pkg::ADDR_GX_HIGH, dsf_pkg::ADDR_GY_HIGH, dsf_pkg::ADDR_GZ_HIGH};
    logic [31:0] v [3] = '{32'h4e200000, 32'hfffffffe, 32'h00000001};
    gyro = {v[0], v[1], v[2]};
    for (int a = 0; a < 3; a++) begin
      rd(hi[a], d); chk(d, v[a][31:16]);
      rd(lo[a], d); chk(d, v[a][15:0]);
    end
  endtask : t_gyro

  // A low clock enable must freeze the flags against a passing event
  task automatic t_freeze;
    clkEn = 1'b0;
    mon = 8'h01; // Overrun while frozen
    step(3);
    mon = '0;
    clkEn = 1'b1;
    step(2);
    rd(dsf_pkg::ADDR_DIAG, d); chk(d, 16'h0000); // Frozen block saw nothing
  endtask : t_freeze

  // Main sequence; all inputs defined at time zero
  initial begin
    mismatches = 0;
    testsRun = 0;
    clkEn = 1'b1;
    clrSeen = 1'b0;
    supplyLow = 1'b0;
    syncMode = 3'h0;
    mon = '0;
    gyro = '0;
    do_reset;
    t_reset;
    t_regs;
    t_flags;
    t_frame;
    t_supply;
    t_cmd;
    t_gyro;
    t_freeze;
    give_verdict;
  end
  // Watchdog well beyond the expected run of about 260 us
  initial begin
    #800us;
    mismatches++;
    give_verdict;
  end
endmodule : tb
